// *** sim/test_uhr_regs.sv ***
// self-checking bench for the run/stop and status register block
`timescale 1ns/1ps
module test_uhr_regs;
   import uhr_pkg::*;

   logic        mclk;
   logic        arst_n;
   logic [31:0] bar_base;
   logic [31:0] reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        reg_rvalid;
   logic        pipe_busy;
   logic [5:0]  stat_evt;
   logic        sched_run;
   logic        xfer_abort;
   logic        halted;
   logic [5:0]  evt_m;
   logic [5:0]  msk;
   logic [31:0] d;
   int          n_errors;
   int          cmp_count;
   int          cycles;
   int          abort_cnt;
   int          i;
   int          seed;

   // design under test
   uhr_regs uut (
      .mclk                   (mclk),
      .arst_n                 (arst_n),
      .bar_base               (bar_base),
      .reg_addr               (reg_addr),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_wdata              (reg_wdata),
      .reg_rdata              (reg_rdata),
      .reg_rvalid             (reg_rvalid),
      .pipe_busy              (pipe_busy),
      .stat_evt               (stat_evt),
      .sched_run              (sched_run),
      .xfer_abort             (xfer_abort),
      .controller_halted_flag (halted)
   );

   // 20 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // hang guard and abort length counter
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         end_of_test();
      end
   end
   always @(negedge mclk)
      if (xfer_abort === 1'b1) abort_cnt++;

   // expected status image
   function logic [31:0] sts(input logic h, input logic [5:0] e);
      sts = 32'(e);
      sts[UHR_STS_HALT_BIT] = h;
   endfunction

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wr(input logic [31:0] ofs, input logic [31:0] v);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = bar_base + ofs;
      reg_wdata = v;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask

   // read answer is looked at in its single valid cycle
   task rd_chk(input logic [31:0] ofs, input logic [31:0] exp);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = bar_base + ofs;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk({31'h0, reg_rvalid}, 32'h1);
      chk(reg_rdata, exp);
   endtask

   task evt(input logic [5:0] v);
      @(negedge mclk);
      stat_evt = v;
      evt_m = evt_m | v;
      @(negedge mclk);
      stat_evt = 6'h00;
   endtask

   task idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // main sequence
   initial
   begin
      seed = 94242;
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      pipe_busy = 1'b0;
      stat_evt = 6'h00;
      evt_m = 6'h00;
      bar_base = $random(seed);
      bar_base[7:0] = 8'h00;
      repeat (6) @(negedge mclk);
      arst_n = 1'b1;
      chk({30'h0, halted, sched_run}, 32'h2);
      rd_chk(UHR_STS_OFS, sts(1'b1, 6'h00));
      $display("test reset done");
      wr(UHR_CMD_OFS, 32'h1);
      idle(2);
      chk({30'h0, halted, sched_run}, 32'h1);
      rd_chk(UHR_CMD_OFS, 32'h1);
      $display("test run done");
      for (i = 0; i < 8; i++)
      begin
         evt(6'($random(seed)));
         rd_chk(UHR_STS_OFS, sts(1'b0, evt_m));
         msk = 6'($random(seed));
         d = $random(seed);
         d[5:0] = msk;
         wr(UHR_STS_OFS, d);
         evt_m = evt_m & ~msk;
         rd_chk(UHR_STS_OFS, sts(1'b0, evt_m));
      end
      // event and clear of the same bits in one cycle: the event wins
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = bar_base + UHR_STS_OFS;
      reg_wdata = 32'hFFFF_FFFF;
      stat_evt = 6'h09;
      @(negedge mclk);
      reg_wr = 1'b0;
      stat_evt = 6'h00;
      evt_m = 6'h09;
      rd_chk(UHR_STS_OFS, sts(1'b0, evt_m));
      evt(6'h2A);
      wr(32'h28, 32'hFFFF_FFFF);
      rd_chk(32'h28, 32'h0);
      rd_chk(UHR_STS_OFS, sts(1'b0, evt_m));
      $display("test status done");
      pipe_busy = 1'b1;
      wr(UHR_CMD_OFS, 32'h0);
      idle(2);
      chk({30'h0, halted, sched_run}, 32'h0);
      idle(5);
      chk({30'h0, halted, sched_run}, 32'h0);
      pipe_busy = 1'b0;
      idle(2);
      chk({30'h0, halted, sched_run}, 32'h2);
      $display("test stop done");
      // run set again while draining resumes, then a stop with idle pipe
      wr(UHR_CMD_OFS, 32'h1);
      idle(2);
      pipe_busy = 1'b1;
      wr(UHR_CMD_OFS, 32'h0);
      idle(2);
      chk({30'h0, halted, sched_run}, 32'h0);
      wr(UHR_CMD_OFS, 32'h1);
      idle(2);
      chk({30'h0, halted, sched_run}, 32'h1);
      pipe_busy = 1'b0;
      wr(UHR_CMD_OFS, 32'h0);
      idle(2);
      chk({30'h0, halted, sched_run}, 32'h2);
      $display("test resume done");
      evt(6'h15);
      chk({31'h0, halted}, 32'h1);
      abort_cnt = 0;
      wr(UHR_CMD_OFS, 32'h2);
      wr(UHR_CMD_OFS, 32'h0);
      rd_chk(UHR_CMD_OFS, 32'h2);
      // run and a second reset request while resetting are both ignored
      wr(UHR_CMD_OFS, 32'h3);
      idle(14);
      chk(32'(abort_cnt), 32'(UHR_RST_CYCLES));
      rd_chk(UHR_STS_OFS, sts(1'b1, 6'h00));
      chk({30'h0, halted, sched_run}, 32'h2);
      rd_chk(UHR_CMD_OFS, 32'h0);
      $display("test controller reset done");
      end_of_test();
   end

endmodule

// *** verilog/uhr_pkg.sv ***
// constants for the host controller run/stop and status registers
package uhr_pkg;

   // register offsets from the memory base address
   localparam logic [31:0] UHR_CMD_OFS = 32'h0000_0020;
   localparam logic [31:0] UHR_STS_OFS = 32'h0000_0024;

   // command register field positions
   localparam int UHR_CMD_RUN_BIT = 0;
   localparam int UHR_CMD_RST_BIT = 1;

   // status register layout: sticky event bits low, halted flag above
   localparam int          UHR_EVT_W       = 6;
   localparam int          UHR_STS_HALT_BIT = 12;
   localparam logic [31:0] UHR_STS_MASK    = 32'h0000_103F;

   // reset values
   localparam logic                 UHR_RUN_RST = 1'b0;
   localparam logic [UHR_EVT_W-1:0] UHR_EVT_RST = 6'h00;

   // controller reset duration
   localparam int UHR_CLK_NS     = 50;
   localparam int UHR_RST_NS     = 500;
   localparam int UHR_RST_CYCLES = (UHR_RST_NS + UHR_CLK_NS - 1) / UHR_CLK_NS;

   // run/stop sequencer states
   typedef enum logic [1:0] {
      UHR_HALTED,
      UHR_RUNNING,
      UHR_DRAINING
   } uhr_state_t;

endpackage

// *** verilog/uhr_regs.sv ***
// run/stop control, halted flag and write-one-to-clear status register
// Functional notes
// - run bit one runs the schedule, zero stops; runs while bit is set
// - after run clears, active pipeline transactions finish before halting
// - halted flag rises only after the pipeline empties and stop is reached, or at once on controller reset
// - status shows pending events and controller states only
// - no per-transaction serial bus result appears in the status register
// - writing one clears a status bit; writing zero leaves it
// - status register decoded at memory base address plus 24h
// - controller reset returns state and registers to initial values
// - reset control self-clears at completion; writing zero cannot end it
`timescale 1ns/1ps
module uhr_regs #(
   parameter int EVT_W      = uhr_pkg::UHR_EVT_W,
   parameter int RST_CYCLES = uhr_pkg::UHR_RST_CYCLES
)
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             arst_n,
   // memory-mapped register access
   input  wire logic [31:0]      bar_base,
   input  wire logic [31:0]      reg_addr,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [31:0]      reg_wdata,
   output logic      [31:0]      reg_rdata,
   output logic                  reg_rvalid,
   // schedule engine
   input  wire logic             pipe_busy,
   input  wire logic [EVT_W-1:0] stat_evt,
   output logic                  sched_run,
   output logic                  xfer_abort,
   output logic                  controller_halted_flag
);
   import uhr_pkg::*;

   uhr_state_t        state_r;
   uhr_state_t        state_nxt;
   logic              run_control_r;
   logic [EVT_W-1:0]  evt_r;
   logic [31:0]       rdata_r;
   logic              rvalid_r;
   logic              rst_active;
   logic              rst_start;
   logic              cmd_hit;
   logic              sts_hit;
   logic [31:0]       sts_value;
   logic [31:0]       cmd_value;

   // address match against base plus offset
   function automatic logic addr_hit(input logic [31:0] a,
                                     input logic [31:0] base,
                                     input logic [31:0] ofs);
      addr_hit = (a == 32'(base + ofs));
   endfunction

   // register decode
   assign cmd_hit = addr_hit(reg_addr, bar_base, UHR_CMD_OFS);
   assign sts_hit = addr_hit(reg_addr, bar_base, UHR_STS_OFS);

   // only a written one starts the reset; a zero is ignored
   assign rst_start = reg_wr && cmd_hit && reg_wdata[UHR_CMD_RST_BIT];

   uhr_rst_seq #(
      .CYCLES (RST_CYCLES)
   ) u_rst (
      .mclk   (mclk),
      .arst_n (arst_n),
      .start  (rst_start),
      .active (rst_active),
      .done   ()
   );

   // run control bit; forced to stop by controller reset
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         run_control_r <= UHR_RUN_RST;
      else if (rst_active)
         run_control_r <= UHR_RUN_RST;
      else if (reg_wr && cmd_hit)
         run_control_r <= reg_wdata[UHR_CMD_RUN_BIT];
   end

   // run/stop sequencer next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         UHR_HALTED:
            if (run_control_r)
               state_nxt = UHR_RUNNING;
         UHR_RUNNING:
            if (!run_control_r)
               state_nxt = pipe_busy ? UHR_DRAINING : UHR_HALTED;
         UHR_DRAINING:
            if (run_control_r)
               state_nxt = UHR_RUNNING;
            else if (!pipe_busy)
               state_nxt = UHR_HALTED;
         default:
            state_nxt = UHR_HALTED;
      endcase
      if (rst_active)
         state_nxt = UHR_HALTED;
   end

   // sequencer state
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= UHR_HALTED;
      else
         state_r <= state_nxt;
   end

   // sticky events; a new event wins over a same-cycle clear
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         evt_r <= UHR_EVT_RST;
      else if (rst_active)
         evt_r <= UHR_EVT_RST;
      else if (reg_wr && sts_hit)
         evt_r <= (evt_r & ~reg_wdata[EVT_W-1:0]) | stat_evt;
      else
         evt_r <= evt_r | stat_evt;
   end

   // register images; only events and controller state are reported
   always_comb
   begin
      sts_value                  = 32'h0000_0000;
      sts_value[EVT_W-1:0]       = evt_r;
      sts_value[UHR_STS_HALT_BIT] = (state_r == UHR_HALTED);
      cmd_value                  = 32'h0000_0000;
      cmd_value[UHR_CMD_RUN_BIT] = run_control_r;
      cmd_value[UHR_CMD_RST_BIT] = rst_active;
   end

   // read data, one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rvalid_r <= reg_rd;
         if (!reg_rd)
            rdata_r <= rdata_r;
         else if (sts_hit)
            rdata_r <= sts_value;
         else if (cmd_hit)
            rdata_r <= cmd_value;
         else
            rdata_r <= 32'h0000_0000;
      end
   end

   // outputs
   assign reg_rdata              = rdata_r;
   assign reg_rvalid             = rvalid_r;
   assign sched_run              = (state_r == UHR_RUNNING);
   assign xfer_abort             = rst_active;
   assign controller_halted_flag = (state_r == UHR_HALTED);

   // run set with no reset pending starts execution on the next cycle
   property p_run_starts;
      @(posedge mclk) disable iff (!arst_n)
      (run_control_r && !rst_active && !rst_start) |=> sched_run;
   endproperty
   a_run_starts: assert property (p_run_starts)
      else $error("schedule not running while run bit set");

   // clearing run never halts while a transaction is in the pipeline
   property p_drain;
      @(posedge mclk) disable iff (!arst_n)
      (!controller_halted_flag && pipe_busy && !rst_active)
         |=> !controller_halted_flag;
   endproperty
   a_drain: assert property (p_drain)
      else $error("halted with transaction still active");

   // halted rises only from an empty pipeline or a reset
   property p_halt_cause;
      @(posedge mclk) disable iff (!arst_n)
      $rose(controller_halted_flag)
         |-> (!$past(pipe_busy) && !$past(run_control_r))
             || $past(rst_active);
   endproperty
   a_halt_cause: assert property (p_halt_cause)
      else $error("halted flag rose without a finished stop");

   // status read shows nothing beyond events and halted
   property p_sts_clean;
      @(posedge mclk) disable iff (!arst_n)
      (reg_rd && sts_hit) |=> ((reg_rdata & ~UHR_STS_MASK) == 32'h0);
   endproperty
   a_sts_clean: assert property (p_sts_clean)
      else $error("status read carries undefined bits");

   // write-one-to-clear with set winning
   property p_w1c;
      @(posedge mclk) disable iff (!arst_n)
      (reg_wr && sts_hit && !rst_active)
         |=> evt_r == ($past(evt_r & ~reg_wdata[EVT_W-1:0])
                       | $past(stat_evt));
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("status write-one-to-clear misbehaved");

   // status read at base plus offset returns the live image
   property p_sts_read;
      @(posedge mclk) disable iff (!arst_n)
      (reg_rd && sts_hit) |=> reg_rvalid && (reg_rdata == $past(sts_value));
   endproperty
   a_sts_read: assert property (p_sts_read)
      else $error("status read returned wrong data");

   // controller reset clears run, events and sequencer state
   property p_reset_clears;
      @(posedge mclk) disable iff (!arst_n)
      rst_active |=> (!run_control_r && evt_r == '0
                      && controller_halted_flag);
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("controller reset left state behind");

   // reset cannot be ended early by software
   property p_reset_holds;
      @(posedge mclk) disable iff (!arst_n)
      $rose(rst_active) |-> rst_active [*8];
   endproperty
   a_reset_holds: assert property (p_reset_holds)
      else $error("controller reset ended early");

   // halted drops one cycle after run is set
   property p_resume;
      @(posedge mclk) disable iff (!arst_n)
      (controller_halted_flag && run_control_r && !rst_active && !rst_start)
         |=> !controller_halted_flag;
   endproperty
   a_resume: assert property (p_resume)
      else $error("halted flag stuck after run set");

endmodule

// *** verilog/uhr_rst_seq.sv ***
// controller reset sequencer: holds reset for a fixed number of cycles
`timescale 1ns/1ps
module uhr_rst_seq #(
   parameter int CYCLES = uhr_pkg::UHR_RST_CYCLES,
   parameter int CNT_W  = 8
)
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic arst_n,
   // control
   input  wire logic start,
   output logic      active,
   output logic      done
);
   import uhr_pkg::*;

   logic [CNT_W-1:0] cnt_r;
   logic             active_r;
   logic             done_r;

   // count down while active; a new start while active is ignored
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r    <= '0;
         active_r <= 1'b0;
         done_r   <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (!active_r && start)
         begin
            active_r <= 1'b1;
            cnt_r    <= CNT_W'(CYCLES - 1);
         end
         else if (active_r)
         begin
            if (cnt_r == '0)
            begin
               active_r <= 1'b0;  // self-clearing at completion
               done_r   <= 1'b1;
            end
            else
            begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end

   assign active = active_r;
   assign done   = done_r;

endmodule
